// ==== shared/aopm_pkg.sv ====
// Package: modes, pin positions and constants for the output port pin mux
package aopm_pkg;

	typedef enum logic [1:0] {
		AOPM_MODE_18 = 2'b00,
		AOPM_MODE_16 = 2'b01,
		AOPM_MODE_8 = 2'b10,
		AOPM_MODE_SER = 2'b11
	} aopm_mode_t;

	// Pin positions on the low data port
	localparam int AOPM_PIN_CODING = 0;
	localparam int AOPM_PIN_FORM_LO = 1;
	localparam int AOPM_PIN_FORM_HI = 2;
	localparam int AOPM_PIN_BIT3 = 3;
	localparam int AOPM_PIN_DIV_LO = 4;
	localparam int AOPM_PIN_DIV_HI = 5;
	localparam int AOPM_PIN_SRC = 6;
	localparam int AOPM_LOW_PINS = 7;
	localparam int AOPM_RESULT_W = 18;

	// Reset values
	localparam logic [AOPM_LOW_PINS-1:0] AOPM_PINS_RST = 7'h00;
	localparam logic [AOPM_RESULT_W-1:0] AOPM_WORD_RST = 18'h00000;
	localparam logic [1:0] AOPM_SYNC_RST = 2'h0;

	// Decoded configuration seen by the converter core
	typedef struct packed {
		logic coding_binary;
		logic [1:0] form_select;
		logic [1:0] divider_select;
		logic clock_source_ext;
		logic serial_master;
		logic serial_slave;
	} aopm_cfg_t;

	// Low pin drive: value and enable per pin
	typedef struct packed {
		logic [AOPM_LOW_PINS-1:0] value;
		logic [AOPM_LOW_PINS-1:0] enable;
	} aopm_pins_t;

endpackage

// ==== hdl/aopm_pin_mux.sv ====
// Module: data output port pin-function multiplexer
`timescale 1ns/1ns

// What this block does
// RL1: Mode 0 gives 18-bit, 1 gives 16-bit
// RL2: Mode 3 is serial; low pins configure
// RL3: Mode 0 drives bit 0; coding binary
// RL4: Other modes: coding pin picks MSB inversion
// RL5: Pin 1: bit 1 in mode 0, else form
// RL6: Pin 2: bit 2 mode 0, form modes 1-2
// RL7: Bit 3 pin always driven output
// RL8: Master read-after-convert: divider pins slow clock
// RL9: Other serial setups float divider pins
// RL10: Source low: device is serial master
// RL11: Read-after-convert shifts only after completion
// RL12: Source high: slave on host clock
// RL13: Form-select encoding defined elsewhere, passed out
module aopm_pin_mux #(
	parameter int RESULT_W = 18
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	input wire logic [1:0] mode_i,
	input wire logic read_during_convert_select_i,
	input wire logic [RESULT_W-1:0] result_i,
	input wire logic conversion_done_i,
	input wire logic [aopm_pkg::AOPM_LOW_PINS-1:0] pin_in_i,
	output logic [aopm_pkg::AOPM_LOW_PINS-1:0] pin_out_o,
	output logic [aopm_pkg::AOPM_LOW_PINS-1:0] pin_oe_o,
	output aopm_pkg::aopm_cfg_t cfg_o,
	output logic [RESULT_W-1:0] coded_result_o,
	output logic serial_start_o
);
	import aopm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin input synchronisers
	logic [AOPM_LOW_PINS-1:0] pin_meta_q;
	logic [AOPM_LOW_PINS-1:0] pin_sync_q;
	logic [1:0] mode_meta_q;
	logic [1:0] mode_sync_q;
	logic read_mode_meta_q;
	logic read_mode_sync_q;

	// Two stages for all pin-level inputs
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_meta_q <= AOPM_PINS_RST;
			pin_sync_q <= AOPM_PINS_RST;
			mode_meta_q <= AOPM_SYNC_RST;
			mode_sync_q <= AOPM_SYNC_RST;
			read_mode_meta_q <= 1'b0;
			read_mode_sync_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			pin_meta_q <= pin_in_i;
			pin_sync_q <= pin_meta_q;
			mode_meta_q <= mode_i;
			mode_sync_q <= mode_meta_q;
			read_mode_meta_q <= read_during_convert_select_i;
			read_mode_sync_q <= read_mode_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decoding
	aopm_mode_t mode;
	assign mode = aopm_mode_t'(mode_sync_q);

	// Pin ownership per mode: high means device drives it
	function automatic logic [AOPM_LOW_PINS-1:0] drive_map(
		input aopm_mode_t m);
		logic [AOPM_LOW_PINS-1:0] en;
		en = {AOPM_LOW_PINS{1'b1}};
		case (m)
			AOPM_MODE_18: en = {AOPM_LOW_PINS{1'b1}}; // RL1 RL3
			AOPM_MODE_16, AOPM_MODE_8:
			begin
				en[AOPM_PIN_CODING] = 1'b0; // RL4
				en[AOPM_PIN_FORM_LO] = 1'b0; // RL5
				en[AOPM_PIN_FORM_HI] = 1'b0; // RL6
			end
			AOPM_MODE_SER:
			begin
				en = '0; // RL2
				en[AOPM_PIN_BIT3] = 1'b1; // RL7
				// Divider pins float in every serial setup, master read-after-convert included
				en[AOPM_PIN_DIV_LO] = 1'b0; // RL9
				en[AOPM_PIN_DIV_HI] = 1'b0; // RL9
			end
			default: en = {AOPM_LOW_PINS{1'b1}};
		endcase
		drive_map = en;
	endfunction

	logic src_ext;
	logic master_rac;
	assign src_ext = pin_sync_q[AOPM_PIN_SRC];
	assign master_rac = (mode == AOPM_MODE_SER) && !src_ext && !read_mode_sync_q; // RL8

	// Coded result: straight binary in mode 0 or coding pin high
	logic binary_sel;
	logic [RESULT_W-1:0] coded_d;
	assign binary_sel = (mode == AOPM_MODE_18) || pin_sync_q[AOPM_PIN_CODING]; // RL3 RL4
	assign coded_d = binary_sel ? result_i : {~result_i[RESULT_W-1], result_i[RESULT_W-2:0]};

	////////////////////////////////////////////////////////////////////////////
	// Pin drive registers
	aopm_pins_t pins_d;
	assign pins_d.enable = drive_map(mode);
	assign pins_d.value = coded_d[AOPM_LOW_PINS-1:0];

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_out_o <= AOPM_PINS_RST;
			pin_oe_o <= AOPM_PINS_RST;
		end
		else if (clk_en_i)
		begin
			pin_out_o <= pins_d.value;
			pin_oe_o <= pins_d.enable; // RL5 RL6 RL7
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration and result registers
	aopm_cfg_t cfg_d;
	always_comb
	begin
		cfg_d = '0;
		cfg_d.coding_binary = binary_sel;
		cfg_d.form_select = (mode == AOPM_MODE_16 || mode == AOPM_MODE_8) ?
			pin_sync_q[AOPM_PIN_FORM_HI:AOPM_PIN_FORM_LO] :
			{1'b0, (mode != AOPM_MODE_18) & pin_sync_q[AOPM_PIN_FORM_LO]}; // RL13
		cfg_d.divider_select = master_rac ?
			pin_sync_q[AOPM_PIN_DIV_HI:AOPM_PIN_DIV_LO] : 2'h0; // RL8
		cfg_d.clock_source_ext = src_ext;
		cfg_d.serial_master = (mode == AOPM_MODE_SER) && !src_ext; // RL10
		cfg_d.serial_slave = (mode == AOPM_MODE_SER) && src_ext; // RL12
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cfg_o <= '0;
			coded_result_o <= AOPM_WORD_RST;
		end
		else if (clk_en_i)
		begin
			cfg_o <= cfg_d;
			coded_result_o <= coded_d;
		end
	end

	// Serial start: read-after-convert waits for conversion done
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			serial_start_o <= 1'b0;
		else if (clk_en_i)
			serial_start_o <= (mode == AOPM_MODE_SER) &&
				(read_mode_sync_q || conversion_done_i); // RL11
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence ser_mode_s;
		mode == AOPM_MODE_SER;
	endsequence

	bit3_driven_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL7
		clk_en_i |=> pin_oe_o[AOPM_PIN_BIT3])
		else $error("bit 3 pin not driven");

	mode0_drive_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL1
		clk_en_i && mode == AOPM_MODE_18 |=> pin_oe_o == {AOPM_LOW_PINS{1'b1}})
		else $error("mode 0 not driving all low pins");

	coding_bin_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL3
		clk_en_i && mode == AOPM_MODE_18 |=> coded_result_o == $past(result_i))
		else $error("mode 0 coding not binary");

	coding_twos_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL4
		clk_en_i && mode != AOPM_MODE_18 && !pin_sync_q[AOPM_PIN_CODING]
		|=> coded_result_o[RESULT_W-1] != $past(result_i[RESULT_W-1]))
		else $error("MSB not inverted");

	form_in_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL5
		clk_en_i && mode != AOPM_MODE_18 |=> !pin_oe_o[AOPM_PIN_FORM_LO])
		else $error("form pin driven outside mode 0");

	form_hi_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL6
		clk_en_i && (mode == AOPM_MODE_16 || mode == AOPM_MODE_8)
		|=> !pin_oe_o[AOPM_PIN_FORM_HI])
		else $error("high form pin driven in modes 1 or 2");

	div_float_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL9
		ser_mode_s ##0 clk_en_i |=> pin_oe_o[AOPM_PIN_DIV_HI:AOPM_PIN_DIV_LO] == 2'h0)
		else $error("divider pins driven in serial mode");

	div_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL8
		clk_en_i && !master_rac |=> cfg_o.divider_select == 2'h0)
		else $error("divider active outside master read-after-convert");

	master_sel_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL10
		ser_mode_s ##0 clk_en_i && !src_ext |=> cfg_o.serial_master && !cfg_o.serial_slave)
		else $error("master mode not selected");

	slave_sel_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL12
		ser_mode_s ##0 clk_en_i && src_ext |=> cfg_o.serial_slave && !cfg_o.serial_master)
		else $error("slave mode not selected");

	rac_wait_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL11
		ser_mode_s ##0 clk_en_i && !read_mode_sync_q && !conversion_done_i |=> !serial_start_o)
		else $error("serial start before conversion done");

endmodule // aopm_pin_mux

// ==== verif/aopm_host_model.sv ====
// Host model: drives the configuration pins that the device releases
`timescale 1ns/1ns
module aopm_host_model (
	input wire logic [aopm_pkg::AOPM_LOW_PINS-1:0] dev_val_i,
	input wire logic [aopm_pkg::AOPM_LOW_PINS-1:0] dev_oe_i,
	input wire logic [aopm_pkg::AOPM_LOW_PINS-1:0] host_val_i,
	output logic [aopm_pkg::AOPM_LOW_PINS-1:0] pin_o
);
	import aopm_pkg::*;
	// Wire level: device where it drives, host elsewhere
	assign pin_o = (dev_oe_i & dev_val_i) | (~dev_oe_i & host_val_i);
endmodule // aopm_host_model

// ==== verif/tb.sv ====
// Testbench for the output port pin mux
`timescale 1ns/1ns
module tb;
	import aopm_pkg::*;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [1:0] mode = 2'h0;
	logic read_mode = 1'b0;
	logic clk_en = 1'b1;
	logic done = 1'b0;
	logic [17:0] res = 18'h00000;
	logic [6:0] host = 7'h00;
	logic [6:0] pins;
	logic [6:0] pout;
	logic [6:0] poe;
	aopm_cfg_t cfg;
	logic [17:0] coded;
	logic start;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	//////////////////////////////////////////////////////////////////////
	// Design and host
	aopm_pin_mux i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en),
		.mode_i(mode), .read_during_convert_select_i(read_mode), .result_i(res),
		.conversion_done_i(done), .pin_in_i(pins), .pin_out_o(pout), .pin_oe_o(poe),
		.cfg_o(cfg), .coded_result_o(coded), .serial_start_o(start));
	aopm_host_model i_host (.dev_val_i(pout), .dev_oe_i(poe), .host_val_i(host), .pin_o(pins));
	// Clock and hang guard
	initial
	begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			num_errors++;
			stop_test();
		end
	end
	//////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Set levels, then let them pass the synchronisers
	task automatic apply(input logic [1:0] m, input logic [6:0] h, input logic r,
		input logic [17:0] v);
		@(posedge ref_clk_i);
		#1;
		mode = m;
		host = h;
		read_mode = r;
		done = 1'b0;
		res = v;
		// Mode reaches the enables, then released pins pass the synchronisers
		repeat (8) @(posedge ref_clk_i);
		#1;
	endtask
	//////////////////////////////////////////////////////////////////////
	// Mode 0: all low pins are bus bits, coding binary
	task automatic test_par18();
		apply(AOPM_MODE_18, 7'h00, 1'b0, 18'h2A5C3);
		check(18'(poe), 18'h0007F);
		check(18'(pout), 18'(res[6:0]));
		check(coded, res);
		check(18'(cfg.coding_binary), 18'h00001);
		check(18'(cfg.form_select), 18'h00000);
		check(18'(start), 18'h00000);
		$display("test_par18 done");
	endtask
	// Modes 1, 2: low three pins are inputs
	task automatic test_narrow();
		for (int m = 1; m < 3; m++)
			for (int c = 0; c < 2; c++)
			begin
				apply(2'(m), {4'h0, 2'(m), 1'(c)}, 1'b0, 18'h20005);
				check(18'(poe), 18'h00078);
				check(coded, c ? res : res ^ 18'h20000);
				check(18'(cfg.form_select), 18'(m));
			end
		$display("test_narrow done");
	endtask
	// Mode 3: clock source and read mode combinations
	task automatic test_serial();
		for (int s = 0; s < 2; s++)
			for (int r = 0; r < 2; r++)
			begin
				apply(AOPM_MODE_SER, {1'(s), 6'h31}, 1'(r), 18'h1FFF7);
				check(18'(poe), 18'h00008);
				check(18'(pout[3]), 18'(res[3]));
				check(18'(cfg.serial_master), 18'(s == 0));
				check(18'(cfg.serial_slave), 18'(s));
				check(18'(cfg.clock_source_ext), 18'(s));
				check(18'(start), 18'(r));
				if (s == 0 && r == 0)
					check(18'(cfg.divider_select), 18'h00003);
				else
					check(18'(cfg.divider_select), 18'h00000);
				done = 1'b1;
				repeat (2) @(posedge ref_clk_i);
				#1;
				check(18'(start), 18'h00001);
			end
		$display("test_serial done");
	endtask
	// Clock enable low: mode change must not reach the pins
	task automatic test_freeze();
		@(posedge ref_clk_i);
		#1;
		clk_en = 1'b0;
		mode = AOPM_MODE_18;
		repeat (8) @(posedge ref_clk_i);
		#1;
		check(18'(poe), 18'h00008);
		check(18'(cfg.serial_slave), 18'h00001);
		clk_en = 1'b1;
		repeat (8) @(posedge ref_clk_i);
		#1;
		check(18'(poe), 18'h0007F);
		check(18'(start), 18'h00000);
		$display("test_freeze done");
	endtask
	//////////////////////////////////////////////////////////////////////
	// Verdict
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (12) @(posedge ref_clk_i);
		#1;
		resetn_i = 1'b1;
		test_par18();
		test_narrow();
		test_serial();
		test_freeze();
		stop_test();
	end
endmodule // tb
